// >>> common/mfs_pkg.sv
/*
 * Package of the memory fault status block: register byte addresses, bit
 * positions of the fault status byte, reset values and bus answer constants.
 * Assumes a 32-bit APB register bus with byte addresses on paddr.
 */
package mfs_pkg;

    // ------------------------------------------------------------------------
    // Register byte addresses.
    // ------------------------------------------------------------------------
    localparam logic [31:0] MFS_ADDR_COMBINED_FAULT_STATUS = 32'hE000ED28;
    localparam logic [31:0] MFS_ADDR_FAULT_ADDRESS_REG     = 32'hE000ED34;
    localparam logic [31:0] MFS_ADDR_FAULT_IRQ_MASK        = 32'hE000ED40;

    // ------------------------------------------------------------------------
    // Bit positions inside the memory fault status byte.
    // ------------------------------------------------------------------------
    localparam int MFS_BIT_INSTR_FETCH_VIOLATION  = 0;
    localparam int MFS_BIT_DATA_ACCESS_VIOLATION  = 1;
    localparam int MFS_BIT_RESERVED_LOW           = 2;
    localparam int MFS_BIT_RETURN_UNSTACKING_FAULT = 3;
    localparam int MFS_BIT_ENTRY_STACKING_FAULT   = 4;
    localparam int MFS_BIT_LAZY_FP_SAVE_FAULT     = 5;
    localparam int MFS_BIT_RESERVED_HIGH          = 6;
    localparam int MFS_BIT_FAULT_ADDR_VALID       = 7;

    // Bits that hold state; the reserved positions are absent here.
    localparam logic [7:0] MFS_IMPLEMENTED_MASK = 8'hBB;

    // ------------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------------
    localparam logic [7:0]  MFS_RESET_FAULT_STATUS = 8'h00;
    localparam logic [7:0]  MFS_RESET_IRQ_MASK     = 8'h00;
    localparam logic [31:0] MFS_RESET_FAULT_ADDR   = 32'h00000000;
    localparam logic [31:0] MFS_RESET_PC           = 32'h00000000;
    localparam logic [31:0] MFS_READ_ZERO          = 32'h00000000;

endpackage

// >>> rtl/mfs_sticky_bit.sv
/*
 * One sticky status flag: set by a hardware event, cleared by software
 * writing one to it. Assumes set and clear are single-clock requests on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module mfs_sticky_bit (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset_n,
    // Requests.
    input  wire logic set_evt,
    input  wire logic clear_req,
    // State.
    output logic      flag
);

    logic flag_reg;
    logic flag_next;

    // A set in the same cycle as a clear wins, so no event is ever lost.
    always_comb begin
        flag_next = flag_reg;
        if (clear_req) begin
            flag_next = 1'b0;
        end
        if (set_evt) begin
            flag_next = 1'b1;
        end
    end

    // Register stage only.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule

`default_nettype wire

// >>> rtl/mfs_fault_status.sv
/*
 * Memory fault status byte with its fault address register, interrupt mask
 * and APB slave. Protection checks and the exception sequencer of the core
 * drive the event inputs on clk; software reads and clears over APB.
 * Assumes all core inputs are synchronous to clk and one cycle wide.
 */
// Decided for this implementation: the address map and the APB slave port.
// Operation
// - Flags set on fault and stay set.
// - Flag clears only by writing one or reset.
// - Bit 7 shows fault address is valid.
// - Bit 5 sets on lazy FP save fault.
// - Bit 4 sets on entry stacking fault.
// - Entry stacking fault adjusts SP, no address.
// - Bit 3 sets on return unstacking fault.
// - Unstacking fault chains, keeps stack, no address.
// - Bit 1 sets on data access violation.
// - Data violation records PC and access address.
// - Bit 0 sets on fetch violation, records PC.
// - Non-executable region faults even without protection unit.
// - Fetch violation writes no fault address.
// - Status byte is low byte at fixed address.
`timescale 1ns/10ps
`default_nettype none

module mfs_fault_status (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave.
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Instruction fetch checks.
    input  wire logic        fetch_check_valid,
    input  wire logic        fetch_perm_deny,
    input  wire logic        fetch_region_nonexec,
    input  wire logic        region_unit_enable,
    input  wire logic [31:0] fetch_pc,
    // Data access checks.
    input  wire logic        data_check_valid,
    input  wire logic        data_perm_deny,
    input  wire logic [31:0] data_addr,
    input  wire logic [31:0] data_pc,
    // Exception sequencer events.
    input  wire logic        entry_stack_fault,
    input  wire logic        return_unstack_fault,
    input  wire logic        lazy_fp_fault,
    // Answers to the core.
    output logic [31:0]      stacked_return_pc,
    output logic             entry_sp_adjust,
    output logic             unstack_chain,
    output logic [31:0]      fault_address_reg,
    output logic [7:0]       memory_fault_status,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // Fault event decode.
    // ------------------------------------------------------------------------
    logic       iacc_evt;
    logic       dacc_evt;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [7:0] status_bits;

    // A non-executable hit faults whatever the protection unit state is;
    // plain permission denials only count while that unit is on.
    assign iacc_evt = fetch_check_valid &
                      (fetch_region_nonexec | (region_unit_enable & fetch_perm_deny));

    assign dacc_evt = data_check_valid & data_perm_deny;

    // Each event drives its own flag; only a data violation validates the address.
    always_comb begin
        set_bits = 8'h00;
        set_bits[mfs_pkg::MFS_BIT_INSTR_FETCH_VIOLATION]   = iacc_evt;
        set_bits[mfs_pkg::MFS_BIT_DATA_ACCESS_VIOLATION]   = dacc_evt;
        set_bits[mfs_pkg::MFS_BIT_RETURN_UNSTACKING_FAULT] = return_unstack_fault;
        set_bits[mfs_pkg::MFS_BIT_ENTRY_STACKING_FAULT]    = entry_stack_fault;
        set_bits[mfs_pkg::MFS_BIT_LAZY_FP_SAVE_FAULT]      = lazy_fp_fault;
        set_bits[mfs_pkg::MFS_BIT_FAULT_ADDR_VALID]        = dacc_evt;
    end

    // ------------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------------
    logic apb_setup;
    logic apb_access;
    logic hit_status;
    logic hit_addr;
    logic hit_mask;
    logic hit_any;
    logic status_wr;
    logic addr_wr;
    logic mask_wr;

    assign hit_status = (paddr == mfs_pkg::MFS_ADDR_COMBINED_FAULT_STATUS);
    assign hit_addr   = (paddr == mfs_pkg::MFS_ADDR_FAULT_ADDRESS_REG);
    assign hit_mask   = (paddr == mfs_pkg::MFS_ADDR_FAULT_IRQ_MASK);
    assign hit_any    = hit_status | hit_addr | hit_mask;
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable;

    // Every access completes at once; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = apb_access & ~hit_any;

    // Writes take effect at the access edge; status and mask need byte lane 0 on, the fault address ignores pstrb.
    assign status_wr = apb_access & pwrite & hit_status & pstrb[0];
    assign addr_wr   = apb_access & pwrite & hit_addr;
    assign mask_wr   = apb_access & pwrite & hit_mask & pstrb[0];

    // Writing one clears, writing zero leaves the flag alone.
    assign clr_bits = status_wr ? pwdata[7:0] : 8'h00;

    // ------------------------------------------------------------------------
    // Sticky flags.
    // ------------------------------------------------------------------------
    // One cell per implemented bit; reserved positions hold no state.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            if (mfs_pkg::MFS_IMPLEMENTED_MASK[gi]) begin : g_cell
                mfs_sticky_bit u_flag (
                    .clk       (clk),
                    .reset_n   (reset_n),
                    .set_evt   (set_bits[gi]),
                    .clear_req (clr_bits[gi]),
                    .flag      (status_bits[gi])
                );
            end else begin : g_rsvd
                assign status_bits[gi] = 1'b0;
            end
        end
    endgenerate

    assign memory_fault_status = status_bits;

    // ------------------------------------------------------------------------
    // Address, mask, core answers and read data.
    // ------------------------------------------------------------------------
    logic [31:0] fault_addr_reg;
    logic [31:0] fault_addr_next;
    logic [7:0]  mask_reg;
    logic [7:0]  mask_next;
    logic [31:0] ret_pc_reg;
    logic [31:0] ret_pc_next;
    logic        sp_adjust_reg;
    logic        sp_adjust_next;
    logic        chain_reg;
    logic        chain_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Only a data violation loads the address; stacking, unstacking and fetch
    // faults leave it alone. The hardware load beats a software write.
    always_comb begin
        fault_addr_next = fault_addr_reg;
        if (addr_wr) begin
            fault_addr_next = pwdata;
        end
        if (dacc_evt) begin
            fault_addr_next = data_addr;
        end
    end

    // The stacked PC points at the faulting instruction; data wins a tie
    // because a load or store is older in the pipe than a fetch.
    always_comb begin
        ret_pc_next = ret_pc_reg;
        if (iacc_evt) begin
            ret_pc_next = fetch_pc;
        end
        if (dacc_evt) begin
            ret_pc_next = data_pc;
        end
    end

    // Entry stacking faults still move the SP; unstacking faults chain
    // straight to the handler, keep the old frame and skip a new save.
    always_comb begin
        sp_adjust_next = entry_stack_fault;
        chain_next     = return_unstack_fault;
    end

    // Interrupt mask keeps the status layout.
    always_comb begin
        mask_next = mask_reg;
        if (mask_wr) begin
            mask_next = pwdata[7:0] & mfs_pkg::MFS_IMPLEMENTED_MASK;
        end
    end

    // Read data is captured in the setup cycle so it stands for the access.
    always_comb begin
        prdata_next = prdata_reg;
        if (apb_setup) begin
            prdata_next = mfs_pkg::MFS_READ_ZERO;
            if (hit_status) begin
                prdata_next[7:0] = status_bits;
            end else if (hit_addr) begin
                prdata_next = fault_addr_reg;
            end else if (hit_mask) begin
                prdata_next[7:0] = mask_reg;
            end
        end
    end

    // Register stage only.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_addr_reg <= mfs_pkg::MFS_RESET_FAULT_ADDR;
            ret_pc_reg     <= mfs_pkg::MFS_RESET_PC;
            sp_adjust_reg  <= 1'b0;
            chain_reg      <= 1'b0;
            mask_reg       <= mfs_pkg::MFS_RESET_IRQ_MASK;
            prdata_reg     <= mfs_pkg::MFS_READ_ZERO;
        end else begin
            fault_addr_reg <= fault_addr_next;
            ret_pc_reg     <= ret_pc_next;
            sp_adjust_reg  <= sp_adjust_next;
            chain_reg      <= chain_next;
            mask_reg       <= mask_next;
            prdata_reg     <= prdata_next;
        end
    end

    assign fault_address_reg = fault_addr_reg;
    assign stacked_return_pc = ret_pc_reg;
    assign entry_sp_adjust   = sp_adjust_reg;
    assign unstack_chain     = chain_reg;
    assign prdata            = prdata_reg;

    // Level interrupt while any unmasked flag stands; the address-valid bit
    // is maskable too, though software seldom wants it alone.
    assign irq = |(status_bits & mask_reg);

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    AST_FETCH_FLAG: assert property (
        @(posedge clk) disable iff (!reset_n)
        iacc_evt |=> status_bits[0] && stacked_return_pc == $past(fetch_pc) || $past(dacc_evt))
        else $error("Fetch violation did not set bit 0 or record its PC.");

    AST_NONEXEC_NO_UNIT: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_check_valid && fetch_region_nonexec && !region_unit_enable |=> status_bits[0])
        else $error("Non-executable fetch with unit off did not fault.");

    AST_DATA_ADDR: assert property (
        @(posedge clk) disable iff (!reset_n)
        dacc_evt |=> status_bits[1] && status_bits[7] && fault_address_reg == $past(data_addr)
                     && stacked_return_pc == $past(data_pc))
        else $error("Data violation did not record flag, address or PC.");

    AST_STICKY_HOLD: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> ((($past(status_bits) & ~$past(clr_bits)) & ~status_bits) == 8'h00))
        else $error("A set flag dropped without a write of one.");

    AST_W1C_CLEARS: assert property (
        @(posedge clk) disable iff (!reset_n)
        (clr_bits & ~set_bits) != 8'h00
        |=> (status_bits & $past(clr_bits) & ~$past(set_bits)) == 8'h00)
        else $error("Writing one did not clear the flag.");

    AST_RISE_NEEDS_EVENT: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> ((status_bits & ~$past(status_bits) & ~$past(set_bits)) == 8'h00))
        else $error("A flag rose without its fault event.");

    AST_ENTRY_STACK: assert property (
        @(posedge clk) disable iff (!reset_n)
        entry_stack_fault && !dacc_evt && !addr_wr
        |=> entry_sp_adjust && status_bits[4] && $stable(fault_address_reg))
        else $error("Entry stacking fault mishandled.");

    AST_UNSTACK_CHAIN: assert property (
        @(posedge clk) disable iff (!reset_n)
        return_unstack_fault && !dacc_evt && !addr_wr
        |=> unstack_chain && status_bits[3] && $stable(fault_address_reg) && !entry_sp_adjust
            || $past(entry_stack_fault))
        else $error("Unstacking fault did not chain cleanly.");

    AST_FETCH_NO_ADDR: assert property (
        @(posedge clk) disable iff (!reset_n)
        iacc_evt && !dacc_evt && !addr_wr |=> $stable(fault_address_reg) ##1 1'b1)
        else $error("Fetch violation wrote a fault address.");

    AST_RESERVED_ZERO: assert property (
        @(posedge clk) disable iff (!reset_n)
        status_wr |=> !status_bits[6] && !status_bits[2] && prdata[6] == 1'b0 [*1])
        else $error("Reserved status bits are not zero.");

    AST_READ_BYTE: assert property (
        @(posedge clk) disable iff (!reset_n)
        apb_setup && hit_status |=> prdata[7:0] == $past(status_bits) && prdata[31:8] == 24'h000000)
        else $error("Status read returned wrong data.");

endmodule

`default_nettype wire

// >>> testbench/mfs_core_model.sv
/*
 * Behavioural model of the core's protection checks and exception sequencer.
 * Assumes the bench raises req_go for one clk cycle per event it wants.
 */
`timescale 1ns/10ps
`default_nettype none

module mfs_core_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Requests from the bench.
    input  wire logic        req_go,
    input  wire logic [2:0]  req_kind,
    input  wire logic        req_unit_en,
    input  wire logic [31:0] req_addr,
    input  wire logic [31:0] req_pc,
    // Pins toward the fault status block.
    output logic             fetch_check_valid,
    output logic             fetch_perm_deny,
    output logic             fetch_region_nonexec,
    output logic             region_unit_enable,
    output logic [31:0]      fetch_pc,
    output logic             data_check_valid,
    output logic             data_perm_deny,
    output logic [31:0]      data_addr,
    output logic [31:0]      data_pc,
    output logic             entry_stack_fault,
    output logic             return_unstack_fault,
    output logic             lazy_fp_fault
);
    logic is_fetch;
    logic is_data;

    // Kinds 0 and 1 are fetch checks, kind 2 a data access check.
    assign is_fetch = req_go && (req_kind <= 3'd1);
    assign is_data  = req_go && (req_kind == 3'd2);

    // One-cycle event pulses; idle buses toggle so stale values never look valid.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_check_valid    <= 1'b0;
            fetch_perm_deny      <= 1'b0;
            fetch_region_nonexec <= 1'b0;
            region_unit_enable   <= 1'b0;
            fetch_pc             <= 32'h00000000;
            data_check_valid     <= 1'b0;
            data_perm_deny       <= 1'b0;
            data_addr            <= 32'h00000000;
            data_pc              <= 32'h00000000;
            entry_stack_fault    <= 1'b0;
            return_unstack_fault <= 1'b0;
            lazy_fp_fault        <= 1'b0;
        end else begin
            region_unit_enable   <= req_unit_en;
            fetch_check_valid    <= is_fetch;
            fetch_perm_deny      <= is_fetch && (req_kind == 3'd0);
            fetch_region_nonexec <= is_fetch && (req_kind == 3'd1);
            fetch_pc             <= is_fetch ? req_pc : ~fetch_pc;
            data_check_valid     <= is_data;
            data_perm_deny       <= is_data;
            data_addr            <= is_data ? req_addr : ~data_addr;
            data_pc              <= is_data ? req_pc : ~data_pc;
            entry_stack_fault    <= req_go && (req_kind == 3'd3);
            return_unstack_fault <= req_go && (req_kind == 3'd4);
            lazy_fp_fault        <= req_go && (req_kind == 3'd5);
        end
    end
endmodule

`default_nettype wire

// >>> testbench/tb_memory_fault_status_byte.sv
/*
 * Self-checking bench of the memory fault status block: APB master tasks,
 * core events through the partner model, one task per scenario.
 * Assumes the zero-wait APB slave and one-cycle event latency of the block.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_memory_fault_status_byte;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        req_go = 1'b0;
    logic [2:0]  req_kind = 3'h0;
    logic        unit_en = 1'b0;
    logic [31:0] req_addr = 32'h00000000;
    logic [31:0] req_pc = 32'h00000000;
    logic        fcv, fpd, frn, rue, dcv, dpd, esf, ruf, lff;
    logic [31:0] fpc, dad, dpc;
    logic [31:0] stacked_return_pc, fault_address_reg;
    logic        entry_sp_adjust, unstack_chain, irq;
    logic [7:0]  memory_fault_status;
    logic [7:0]  exp;
    logic [31:0] rd;
    logic        er;
    int          bad_count = 0;
    int          compares = 0;

    localparam logic [31:0] STS = mfs_pkg::MFS_ADDR_COMBINED_FAULT_STATUS;
    localparam logic [31:0] MSK = mfs_pkg::MFS_ADDR_FAULT_IRQ_MASK;
    localparam logic [31:0] FAR = mfs_pkg::MFS_ADDR_FAULT_ADDRESS_REG;
    localparam logic [31:0] DAD = 32'h20000104;

    // 100 MHz clock.
    always #5 clk = ~clk;

    mfs_core_model core_u (.clk(clk), .reset_n(reset_n), .req_go(req_go),
        .req_kind(req_kind), .req_unit_en(unit_en), .req_addr(req_addr), .req_pc(req_pc),
        .fetch_check_valid(fcv), .fetch_perm_deny(fpd), .fetch_region_nonexec(frn),
        .region_unit_enable(rue), .fetch_pc(fpc), .data_check_valid(dcv),
        .data_perm_deny(dpd), .data_addr(dad), .data_pc(dpc), .entry_stack_fault(esf),
        .return_unstack_fault(ruf), .lazy_fp_fault(lff));

    mfs_fault_status dut_u (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_check_valid(fcv),
        .fetch_perm_deny(fpd), .fetch_region_nonexec(frn), .region_unit_enable(rue),
        .fetch_pc(fpc), .data_check_valid(dcv), .data_perm_deny(dpd), .data_addr(dad),
        .data_pc(dpc), .entry_stack_fault(esf), .return_unstack_fault(ruf),
        .lazy_fp_fault(lff), .stacked_return_pc(stacked_return_pc),
        .entry_sp_adjust(entry_sp_adjust), .unstack_chain(unstack_chain),
        .fault_address_reg(fault_address_reg), .memory_fault_status(memory_fault_status),
        .irq(irq));

    // ------------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        compares++;
        if (seen !== expd) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    // One APB transfer; an idle cycle first keeps psel from two drives per step.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers counts as a mismatch.
        if (pready !== 1'b1) begin
            bad_count++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // One core event; the block answers one cycle after the model's pulse.
    task automatic ev(input logic [2:0] k, input logic [31:0] a, input logic [31:0] pc);
        @(posedge clk);
        req_go <= 1'b1;
        req_kind <= k;
        req_addr <= a;
        req_pc <= pc;
        @(posedge clk);
        req_go <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic final_report;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, STS, 32'h00000000, 4'hF);
        check(rd, 32'h00000000);
        check(32'(irq), 32'h00000000);
    endtask

    // Event kinds 2, 1, 3, 4 and 5 in turn; bits must pile up without loss.
    task automatic t_events;
        ev(3'd2, DAD, 32'h08000010);
        exp = 8'h82;
        check(32'(memory_fault_status), 32'(exp));
        check(fault_address_reg, DAD);
        check(stacked_return_pc, 32'h08000010);
        ev(3'd1, 32'h11111111, 32'h08000020);
        exp = exp | 8'h01;
        check(32'(memory_fault_status), 32'(exp));
        check(stacked_return_pc, 32'h08000020);
        check(fault_address_reg, DAD);
        check(32'(entry_sp_adjust), 32'h00000000);
        ev(3'd3, 32'h22222222, 32'h0);
        exp = exp | 8'h10;
        check(32'(memory_fault_status), 32'(exp));
        check(32'(entry_sp_adjust), 32'h00000001);
        check(fault_address_reg, DAD);
        ev(3'd4, 32'h33333333, 32'h0);
        exp = exp | 8'h08;
        check(32'(memory_fault_status), 32'(exp));
        check(32'(unstack_chain), 32'h00000001);
        check(fault_address_reg, DAD);
        ev(3'd5, 32'h44444444, 32'h0);
        exp = exp | 8'h20;
        apb(1'b0, STS, 32'h00000000, 4'hF);
        check(rd, 32'(exp));
    endtask

    // Write-one-to-clear, with zero writes, reserved bits and a dead lane.
    task automatic t_w1c;
        apb(1'b1, STS, 32'h00000000, 4'hF);
        check(32'(memory_fault_status), 32'(exp));
        apb(1'b1, STS, 32'h00000044, 4'hF);
        check(32'(memory_fault_status), 32'(exp));
        apb(1'b1, STS, 32'h00000080, 4'hE);
        check(32'(memory_fault_status), 32'(exp));
        apb(1'b1, STS, 32'h00000080, 4'hF);
        exp = exp & 8'h7F;
        check(32'(memory_fault_status), 32'(exp));
        apb(1'b1, STS, 32'h000000FF, 4'hF);
        check(32'(memory_fault_status), 32'h00000000);
    endtask

    // Permission denial counts only with the protection unit switched on.
    task automatic t_fetch_enable;
        ev(3'd0, 32'h0, 32'h08000030);
        check(32'(memory_fault_status), 32'h00000000);
        @(posedge clk);
        unit_en <= 1'b1;
        ev(3'd0, 32'h0, 32'h08000040);
        check(32'(memory_fault_status), 32'h00000001);
        check(stacked_return_pc, 32'h08000040);
    endtask

    task automatic t_irq;
        check(32'(irq), 32'h00000000);
        apb(1'b1, MSK, 32'h00000001, 4'hF);
        check(32'(irq), 32'h00000001);
        apb(1'b0, MSK, 32'h00000000, 4'hF);
        check(rd, 32'h00000001);
        apb(1'b1, STS, 32'h00000001, 4'hF);
        check(32'(irq), 32'h00000000);
    endtask

    // Software may rewrite the fault address, which must not mark it valid.
    task automatic t_fault_addr;
        apb(1'b1, FAR, 32'h12345678, 4'h0);
        check(fault_address_reg, 32'h12345678);
        apb(1'b0, FAR, 32'h00000000, 4'hF);
        check(rd, 32'h12345678);
        check(32'(memory_fault_status), 32'h00000000);
    endtask

    task automatic t_unmapped;
        apb(1'b0, STS + 32'h4, 32'h00000000, 4'hF);
        check(32'(er), 32'h00000001);
        check(rd, 32'h00000000);
    endtask

    // Main sequence: two reset cycles, then the scenarios in order.
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_events();
        t_w1c();
        t_fetch_enable();
        t_irq();
        t_fault_addr();
        t_unmapped();
        final_report();
    end

    // Watchdog: the run needs well under a thousand cycles.
    initial begin
        #20000;
        bad_count++;
        final_report();
    end
endmodule

`default_nettype wire
